//--- core/spc_pkg.sv
// Package of constants and carrier types for the slave port control register block
package spc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	// Register indices; the byte address is four times the index
	localparam logic [9:0]  SPC_CTRL_INDEX   = 10'h089;
	localparam logic [9:0]  SPC_IRQ_ST_INDEX = 10'h08A;
	localparam logic [9:0]  SPC_IRQ_MK_INDEX = 10'h08B;
	localparam logic [11:0] SPC_CTRL_ADDR    = {SPC_CTRL_INDEX, 2'b00};
	localparam logic [11:0] SPC_IRQ_ST_ADDR  = {SPC_IRQ_ST_INDEX, 2'b00};
	localparam logic [11:0] SPC_IRQ_MK_ADDR  = {SPC_IRQ_MK_INDEX, 2'b00};

	// ************************************************************
	// Control register field positions
	// ************************************************************
	localparam int SPC_IN_PEND_BIT  = 7;
	localparam int SPC_OUT_PEND_BIT = 6;
	localparam int SPC_OVERRUN_BIT  = 5;
	localparam int SPC_MODE_BIT     = 4;
	localparam int SPC_CS_DIR_BIT   = 2;
	localparam int SPC_WR_DIR_BIT   = 1;
	localparam int SPC_RD_DIR_BIT   = 0;

	// Reset values
	localparam logic [2:0] SPC_DIR_RESET  = 3'h7;
	localparam logic       SPC_FLAG_RESET = 1'b0;
	localparam logic [2:0] SPC_IRQ_RESET  = 3'h0;

	// ************************************************************
	// Interrupt status and mask field positions
	// ************************************************************
	localparam int SPC_IRQ_WRITE_BIT = 0;
	localparam int SPC_IRQ_READ_BIT  = 1;
	localparam int SPC_IRQ_OVR_BIT   = 2;
	localparam int SPC_IRQ_WIDTH     = 3;

	// Events from the slave port data path
	typedef struct packed {
		logic ext_write_done;   // External write finished, word latched
		logic ext_read_done;    // External read strobe seen
		logic ext_read_active;  // External read still in progress
		logic fw_read_data;     // Firmware read the input latch
		logic fw_write_data;    // Firmware wrote the output latch
	} spc_event_type;

	// Pin direction controls, 1 means input
	typedef struct packed {
		logic chip_select_dir;
		logic write_strobe_dir;
		logic read_strobe_dir;
	} spc_dir_type;

endpackage

//--- core/spc_ctrl.sv
// Slave port control and strobe direction register with APB access and interrupt
//
// Summary of operation
// - Bit 7 input pending, read only
// - Bit 6 output pending, cleared by host read
// - Bit 5 overrun set on write while pending
// - Overrun cleared only by software writing zero
// - Bit 4 selects slave port mode
// - Bits 2..0 direction of cs, wr, rd
// - Reset: directions one, flags and mode zero
// - Firmware data read clears input pending
// - Output pending stays low until firmware write
// - Mode off holds pending flags clear
// - Write while pending sets overrun, overwrites
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

module spc_ctrl
	import spc_pkg::*;
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Events from the slave port data path
	input  wire spc_event_type           port_events,
	// Control outputs to the data path and pins
	output logic                         slave_port_mode_select,
	output spc_dir_type                  strobe_dir,
	output logic                         input_word_pending,
	output logic                         output_word_pending,
	output logic                         input_overrun_flag,
	// Interrupt
	output logic                         irq
);

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Address match, used for each register of the map
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction

	// ************************************************************
	// State registers
	// ************************************************************
	logic                     in_pend_reg;    // Input word waiting for firmware
	logic                     in_pend_next;
	logic                     out_pend_reg;   // Output word not yet read by host
	logic                     out_pend_next;
	logic                     overrun_reg;    // Sticky overrun detect
	logic                     overrun_next;
	logic                     mode_reg;       // Slave port mode select
	logic                     mode_next;
	spc_dir_type              dir_reg;        // Pin direction bits
	spc_dir_type              dir_next;
	logic [SPC_IRQ_WIDTH-1:0] irq_st_reg;     // Sticky interrupt status
	logic [SPC_IRQ_WIDTH-1:0] irq_st_next;
	logic [SPC_IRQ_WIDTH-1:0] irq_mk_reg;     // Interrupt mask, 1 enables
	logic [SPC_IRQ_WIDTH-1:0] irq_mk_next;
	logic                     irq_reg;        // Registered interrupt line
	logic                     irq_next;

	// APB answer registers
	logic                     pready_reg;
	logic                     pready_next;
	logic [31:0]              prdata_reg;
	logic [31:0]              prdata_next;
	logic                     pslverr_reg;
	logic                     pslverr_next;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire logic access_phase;   // Access phase, answer not yet given
	wire logic commit;         // Edge at which the transfer completes
	wire logic hit_ctrl;       // Control register selected
	wire logic hit_st;         // Interrupt status selected
	wire logic hit_mk;         // Interrupt mask selected
	wire logic mapped;         // Any register selected
	wire logic wr_ctrl;        // Write to control register
	wire logic wr_st;          // Write to interrupt status
	wire logic wr_mk;          // Write to interrupt mask

	// Access phase first cycle lasts until pready is raised
	assign access_phase = psel & penable & ~pready_reg;
	// Write takes effect only at the edge where pready is seen high
	assign commit       = psel & penable & pready_reg;
	assign hit_ctrl     = addr_hit(paddr, SPC_CTRL_ADDR);
	assign hit_st       = addr_hit(paddr, SPC_IRQ_ST_ADDR);
	assign hit_mk       = addr_hit(paddr, SPC_IRQ_MK_ADDR);
	assign mapped       = hit_ctrl | hit_st | hit_mk;
	assign wr_ctrl      = commit & pwrite & hit_ctrl;
	assign wr_st        = commit & pwrite & hit_st;
	assign wr_mk        = commit & pwrite & hit_mk;

	// ************************************************************
	// Event qualification
	// ************************************************************
	wire logic host_wrote;     // External write completed in port mode
	wire logic host_read;      // External read seen in port mode
	wire logic overrun_event;  // External write onto a pending word
	wire logic [SPC_IRQ_WIDTH-1:0] irq_events;

	// Data path events only count while the port is in slave mode
	assign host_wrote    = mode_reg & port_events.ext_write_done;
	assign host_read     = mode_reg & port_events.ext_read_done;
	// The new word overwrites the old one in the data path latch
	assign overrun_event = host_wrote & in_pend_reg;

	// Interrupt sources in status bit order
	assign irq_events = {overrun_event, host_read, host_wrote};

	// ************************************************************
	// Flag next state
	// ************************************************************

	// Input pending: set by host write, cleared by firmware read
	always_comb begin
		if (!mode_reg) begin
			in_pend_next = 1'b0;
		end else if (host_wrote) begin
			// A write in the same cycle as a firmware read wins
			in_pend_next = 1'b1;
		end else if (port_events.fw_read_data) begin
			in_pend_next = 1'b0;
		end else begin
			in_pend_next = in_pend_reg;
		end
	end

	// Output pending: set by firmware write, cleared by host read
	always_comb begin
		if (!mode_reg) begin
			out_pend_next = 1'b0;
		end else if (host_read) begin
			out_pend_next = 1'b0;
		end else if (port_events.fw_write_data && !port_events.ext_read_active) begin
			// A firmware write during a host read goes straight to the pins
			out_pend_next = 1'b1;
		end else begin
			out_pend_next = out_pend_reg;
		end
	end

	// Overrun: hardware or a software write of one sets it, software write of zero clears it
	always_comb begin
		if (overrun_event) begin
			// Set beats a software clear in the same cycle
			overrun_next = 1'b1;
		end else if (wr_ctrl) begin
			// Software may write either value
			overrun_next = pwdata[SPC_OVERRUN_BIT];
		end else begin
			// Mode off leaves it unchanged
			overrun_next = overrun_reg;
		end
	end

	// ************************************************************
	// Writable control fields
	// ************************************************************

	// Mode select and direction bits; bit 3 has no storage
	always_comb begin
		if (wr_ctrl) begin
			mode_next                 = pwdata[SPC_MODE_BIT];
			dir_next.chip_select_dir  = pwdata[SPC_CS_DIR_BIT];
			dir_next.write_strobe_dir = pwdata[SPC_WR_DIR_BIT];
			dir_next.read_strobe_dir  = pwdata[SPC_RD_DIR_BIT];
		end else begin
			mode_next = mode_reg;
			dir_next  = dir_reg;
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************

	// Each status bit is sticky, cleared by writing one
	genvar gi;
	generate
		for (gi = 0; gi < SPC_IRQ_WIDTH; gi++) begin : g_irq
			// New event wins over a write-one-to-clear
			assign irq_st_next[gi] = irq_events[gi] |
				(irq_st_reg[gi] & ~(wr_st & pwdata[gi]));
		end
	endgenerate

	// Mask is a plain read/write field
	assign irq_mk_next = wr_mk ? pwdata[SPC_IRQ_WIDTH-1:0] : irq_mk_reg;
	// Level line, high while an enabled status bit is set
	assign irq_next    = |(irq_st_next & irq_mk_next);

	// ************************************************************
	// Read data and answer
	// ************************************************************
	logic [7:0] ctrl_view;  // Control register as software sees it

	// Bit 3 is not implemented and reads zero
	always_comb begin
		ctrl_view                   = 8'h00;
		ctrl_view[SPC_IN_PEND_BIT]  = in_pend_reg;
		ctrl_view[SPC_OUT_PEND_BIT] = out_pend_reg;
		ctrl_view[SPC_OVERRUN_BIT]  = overrun_reg;
		ctrl_view[SPC_MODE_BIT]     = mode_reg;
		ctrl_view[SPC_CS_DIR_BIT]   = dir_reg.chip_select_dir;
		ctrl_view[SPC_WR_DIR_BIT]   = dir_reg.write_strobe_dir;
		ctrl_view[SPC_RD_DIR_BIT]   = dir_reg.read_strobe_dir;
	end

	// Answer one cycle into the access phase, then drop at once
	assign pready_next  = access_phase;
	assign pslverr_next = access_phase & ~mapped;

	// Read data is captured with pready so it is stable when sampled
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (access_phase && !pwrite) begin
			if (hit_ctrl) begin
				prdata_next = {24'h00_0000, ctrl_view};
			end else if (hit_st) begin
				prdata_next = {29'h0000_0000, irq_st_reg};
			end else if (hit_mk) begin
				prdata_next = {29'h0000_0000, irq_mk_reg};
			end else begin
				// Unmapped reads return zero with an error
				prdata_next = 32'h0000_0000;
			end
		end
	end

	// ************************************************************
	// Flip-flops
	// ************************************************************

	// Port flags and control fields
	always_ff @(posedge clock) begin
		if (rst) begin
			in_pend_reg  <= SPC_FLAG_RESET;
			out_pend_reg <= SPC_FLAG_RESET;
			overrun_reg  <= SPC_FLAG_RESET;
			mode_reg     <= SPC_FLAG_RESET;
			dir_reg      <= SPC_DIR_RESET;
		end else begin
			in_pend_reg  <= in_pend_next;
			out_pend_reg <= out_pend_next;
			overrun_reg  <= overrun_next;
			mode_reg     <= mode_next;
			dir_reg      <= dir_next;
		end
	end

	// Interrupt state
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_st_reg <= SPC_IRQ_RESET;
			irq_mk_reg <= SPC_IRQ_RESET;
			irq_reg    <= 1'b0;
		end else begin
			irq_st_reg <= irq_st_next;
			irq_mk_reg <= irq_mk_next;
			irq_reg    <= irq_next;
		end
	end

	// Bus answer
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	// ************************************************************
	// Outputs, each straight from a flip-flop
	// ************************************************************
	assign prdata                 = prdata_reg;
	assign pready                 = pready_reg;
	assign pslverr                = pslverr_reg;
	assign slave_port_mode_select = mode_reg;
	assign strobe_dir             = dir_reg;
	assign input_word_pending     = in_pend_reg;
	assign output_word_pending    = out_pend_reg;
	assign input_overrun_flag     = overrun_reg;
	assign irq                    = irq_reg;

endmodule // spc_ctrl

//--- testbench/spc_ctrl_assertions.sv
// Concurrent checks on the slave port control register ports
`timescale 1ns/1ps
module spc_ctrl_assertions
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic          clock,
	input wire logic          rst,
	// APB
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	// Port side
	input wire spc_event_type port_events,
	input wire logic          slave_port_mode_select,
	input wire spc_dir_type   strobe_dir,
	input wire logic          input_word_pending,
	input wire logic          output_word_pending,
	input wire logic          input_overrun_flag
);
	// ************
	// Decodes
	// ************
	// Completed control register accesses
	wire ctl_wr = psel && penable && pready && pwrite && paddr == SPC_CTRL_ADDR;
	wire ctl_rd = psel && penable && pready && !pwrite && paddr == SPC_CTRL_ADDR;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ************
	// Properties
	// ************
	a_reset_values: assert property ($fell(rst) |-> strobe_dir == 3'h7 &&
		!slave_port_mode_select && !input_word_pending && !output_word_pending && !input_overrun_flag)
		else $error("reset values wrong");
	a_mode_off_clear: assert property (!slave_port_mode_select |=>
		!input_word_pending && !output_word_pending) else $error("pending flag while mode off");
	a_overrun_set: assert property (slave_port_mode_select && input_word_pending &&
		port_events.ext_write_done && !ctl_wr |=> input_overrun_flag && input_word_pending)
		else $error("overrun not set");
	a_overrun_hold: assert property (input_overrun_flag && !ctl_wr |=> input_overrun_flag)
		else $error("overrun cleared by itself");
	a_pending_set: assert property (slave_port_mode_select && port_events.ext_write_done && !ctl_wr
		|=> input_word_pending) else $error("input pending not set");
	a_pending_clear: assert property (input_word_pending && port_events.fw_read_data &&
		!port_events.ext_write_done |=> !input_word_pending) else $error("input pending not cleared");
	a_out_read_clear: assert property (port_events.ext_read_done |=> !output_word_pending)
		else $error("output pending not cleared");
	a_out_stays_low: assert property (!output_word_pending && !port_events.fw_write_data
		|=> !output_word_pending) else $error("output pending rose without write");
	a_ctrl_write: assert property (ctl_wr |=> strobe_dir == $past(pwdata[2:0]) &&
		slave_port_mode_select == $past(pwdata[4])) else $error("control write lost");
	a_bit3_zero: assert property (ctl_rd |-> !prdata[3] && prdata[31:8] == 24'h0)
		else $error("unused bits read nonzero");
	// Main scenarios reached
	c_overrun: cover property (input_word_pending && port_events.ext_write_done);
	c_host_read: cover property (port_events.ext_read_done && output_word_pending);
	c_mode_off: cover property ($fell(slave_port_mode_select));
endmodule // spc_ctrl_assertions

bind spc_ctrl spc_ctrl_assertions u_spc_ctrl_assertions (.clock, .rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .port_events, .slave_port_mode_select, .strobe_dir, .input_word_pending,
	.output_word_pending, .input_overrun_flag);

//--- testbench/spc_host_model.sv
// Behavioural model of the external processor on the slave port
`timescale 1ns/1ps
module spc_host_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Bench commands and strobe length
	input  wire logic       wr_go,
	input  wire logic       rd_go,
	input  wire logic [3:0] len,
	// Events seen by the device
	output logic            wr_done,
	output logic            rd_done,
	output logic            rd_active
);
	logic [4:0] wr_cnt_reg; // Cycles left of the write strobe
	logic [3:0] rd_cnt_reg; // Cycles left of the read strobe
	// Write lands when its strobe ends; a read is seen at once, so slow strobes stress the flags
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_cnt_reg <= 5'h0;
			rd_cnt_reg <= 4'h0;
		end else begin
			wr_cnt_reg <= wr_go ? {1'h0, len} + 5'h1 : wr_cnt_reg - 5'(wr_cnt_reg != 5'h0);
			rd_cnt_reg <= rd_go ? len : rd_cnt_reg - 4'(rd_cnt_reg != 4'h0);
		end
	end
	assign wr_done = wr_cnt_reg == 5'h1;
	assign rd_done = rd_go;
	assign rd_active = rd_cnt_reg != 4'h0;
endmodule // spc_host_model

//--- testbench/tb_spc_ctrl.sv
// Self-checking bench for the slave port control register
`timescale 1ns/1ps
module tb_spc_ctrl;
	import spc_pkg::*;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wgo = 0, rgo = 0;
	logic pready, pslverr, irq, mode, inp, outp, ovr, hw, hr, ha;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic [1:0] fwv = 2'h0; // Firmware read and write pulses
	logic [3:0] len = 4'h0;
	spc_dir_type dir;
	logic [32:0] expq[$]; // Expected {pslverr, prdata} of each read
	int miscompares = 0, num_checks = 0, seed = 32'hCA406BED;
	always #50 clock = ~clock;
	spc_ctrl u_spc_ctrl (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.port_events({hw, hr, ha, fwv}), .slave_port_mode_select(mode), .strobe_dir(dir),
		.input_word_pending(inp), .output_word_pending(outp), .input_overrun_flag(ovr), .irq);
	spc_host_model u_spc_host_model (.clock, .rst, .wr_go(wgo), .rd_go(rgo), .len, .wr_done(hw),
		.rd_done(hr), .rd_active(ha));
	// ************
	// Tasks
	// ************
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask
	task automatic fw(input logic [1:0] k);
		@(posedge clock);
		fwv <= k;
		@(posedge clock);
		fwv <= 2'h0;
	endtask
	// External access; reads use a long strobe so firmware can act during it
	task automatic host(input logic r);
		@(posedge clock);
		len <= r ? 4'hF : 4'($random(seed));
		rgo <= r;
		wgo <= !r;
		@(posedge clock);
		rgo <= 1'h0;
		wgo <= 1'h0;
		while (!hw && !r) @(posedge clock);
		repeat (2) @(posedge clock);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Read results are compared in order as they complete
	always @(posedge clock)
		if (psel && penable && pready === 1'h1 && !pwrite) check({pslverr, prdata}, expq.pop_front());
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		print_verdict;
	end
	// ************
	// Scenarios
	// ************
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		rd(SPC_CTRL_ADDR, 33'h7);
		apb(1'h1, 12'h300, 32'hFFFFFFFF);
		rd(12'h300, 33'h100000000);
		$display("reset and map test done");
		for (int i = 0; i < 8; i++) begin
			d = {29'($random(seed)), i[2:0]};
			apb(1'h1, SPC_CTRL_ADDR, d);
			rd(SPC_CTRL_ADDR, {27'h0, d[5:4], 1'h0, d[2:0]});
		end
		$display("field test done");
		apb(1'h1, SPC_CTRL_ADDR, 32'h17);
		apb(1'h1, SPC_IRQ_ST_ADDR, 32'h7);
		apb(1'h1, SPC_IRQ_MK_ADDR, 32'h1);
		host(1'h0);
		check({32'h0, irq}, 33'h1);
		rd(SPC_CTRL_ADDR, 33'h97);
		host(1'h0);
		rd(SPC_CTRL_ADDR, 33'hB7);
		rd(SPC_IRQ_ST_ADDR, 33'h5);
		apb(1'h1, SPC_IRQ_ST_ADDR, 32'h5);
		repeat (2) @(posedge clock);
		check({32'h0, irq}, 33'h0);
		fw(2'h2);
		rd(SPC_CTRL_ADDR, 33'h37);
		$display("input test done");
		fw(2'h1);
		rd(SPC_CTRL_ADDR, 33'h77);
		host(1'h1);
		rd(SPC_CTRL_ADDR, 33'h37);
		rd(SPC_IRQ_ST_ADDR, 33'h2);
		fw(2'h1);
		rd(SPC_CTRL_ADDR, 33'h37);
		while (ha) @(posedge clock);
		fw(2'h1);
		rd(SPC_CTRL_ADDR, 33'h77);
		$display("output test done");
		host(1'h0);
		rd(SPC_CTRL_ADDR, 33'hF7);
		apb(1'h1, SPC_CTRL_ADDR, 32'h27);
		host(1'h0);
		rd(SPC_CTRL_ADDR, 33'h27);
		check({26'h0, inp, outp, ovr, mode, dir}, 33'h17);
		$display("mode test done");
		print_verdict;
	end
endmodule // tb_spc_ctrl
